// ### logic/eth_tx_cfg.svh
// Constants for the transmit packet source: field layout, depths and timing counts.
`ifndef ETH_TX_CFG_SVH
`define ETH_TX_CFG_SVH

// One buffered word is one 8-byte segment plus its sideband.
`define WORD_DATA_W      64
`define WORD_W           69
`define FW_LAST          64
`define FW_EMPTY_LSB     65
`define FW_EMPTY_W       3
`define FW_ERROR         68

// Segment and wide bus geometry.
`define SEG_BYTES        8
`define SEG_BUS_W        128
`define WIDE_BUS_W       256
`define WIDE_KEEP_W      32
`define WIDE_WORDS       4

// Buffer depth in words and width of its fill level.
`define FIFO_DEPTH       32
`define FIFO_LEVEL_W     6

// Clock period and how long the device reset is held after our own reset ends.
`define CLK_PERIOD_NS    10
`define RESET_HOLD_NS    160
`define RESET_HOLD_CYC   ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W       5

`endif

// ### logic/eth_tx_pkg.sv
// Types shared by the transmit packet source modules.
package eth_tx_pkg;

  // Reset sequencer states, one-hot.
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } link_state_type;

  // One buffered word: data, last flag, empty count and error flag.
  typedef logic [68:0] buf_word_type;

endpackage

// ### logic/stream_fifo.sv
// Word FIFO with one write port and a read side that shows and pops several heads at once.
`timescale 1ns/1ps
`include "eth_tx_cfg.svh"

module stream_fifo
  import eth_tx_pkg::*;
#(
  parameter int WIDTH = 69,
  parameter int DEPTH = 32,
  parameter int LANES = 4,
  parameter int LW    = $clog2(DEPTH + 1),
  parameter int AW    = $clog2(DEPTH),
  parameter int PW    = $clog2(LANES + 1)
) (
  input  wire logic                        core_clk, // System clock.
  input  wire logic                        rst_n,    // Synchronous reset, active low.
  input  wire logic                        wrValid,  // Write word offered.
  output logic                             wrReady,  // Room for a word.
  input  wire logic [WIDTH-1:0]            wrData,   // Word to write.
  output logic                             rdValid,  // At least one word held.
  input  wire logic                        rdReady,  // Consumer pops rdPop words.
  input  wire logic [PW-1:0]               rdPop,    // Number of words popped.
  output logic [LANES-1:0][WIDTH-1:0]      rdHeads,  // Oldest words, head first.
  output logic [LW-1:0]                    rdLevel   // Words held.
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [LW-1:0]    level_ff;
  wire              push = wrValid && wrReady;
  wire  [PW-1:0]    popNum = rdReady ? rdPop : PW'(0);

  // Full and empty come straight from the level so back-pressure is exact.
  assign wrReady = (level_ff != LW'(DEPTH));
  assign rdValid = (level_ff != LW'(0));
  assign rdLevel = level_ff;

  // Heads beyond the level hold stale words; the consumer masks them by level.
  for (genvar i = 0; i < LANES; i++) begin : g_head
    assign rdHeads[i] = mem[rdPtr_ff + AW'(i)];
  end

  // Storage has no reset; only pointers and level carry state.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_ff] <= wrData;
    end
  end

  // Pointers and level.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      level_ff <= '0;
    end else begin
      wrPtr_ff <= wrPtr_ff + AW'(push);
      rdPtr_ff <= rdPtr_ff + AW'(popNum);
      level_ff <= level_ff + LW'(push) - LW'(popNum);
    end
  end

  // The consumer never pops more than is held.
  property p_no_overpop;
    @(posedge core_clk) disable iff (!rst_n)
      rdReady |-> (LW'(rdPop) <= level_ff);
  endproperty
  a_no_overpop: assert property (p_no_overpop) else $error("fifo popped beyond level");

endmodule

// ### logic/seg_lane.sv
// Registered sideband and data of one 8-byte segment of the segmented transmit bus.
`timescale 1ns/1ps
`include "eth_tx_cfg.svh"

module seg_lane
  import eth_tx_pkg::*;
(
  input  wire logic                      core_clk,   // System clock.
  input  wire logic                      rst_n,      // Synchronous reset, active low.
  input  wire logic                      load,       // Segment takes a new value.
  input  wire logic                      take,       // A word is placed in this segment.
  input  wire logic                      isStart,    // Word opens a frame.
  input  wire buf_word_type              word,       // Word from the buffer.
  output logic [`WORD_DATA_W-1:0]        segData,    // Segment data, byte 0 in low bits.
  output logic                           segEnable,  // Segment carries data.
  output logic                           segStart,   // Frame starts here.
  output logic                           segEnd,     // Frame ends here.
  output logic [`FW_EMPTY_W-1:0]         segEmpty,   // Trailing empty bytes.
  output logic                           segError    // Packet error on the end word.
);

  wire wordEnd = take && word[`FW_LAST];

  // Empty and error are driven only on the end word and stay zero otherwise.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      segData   <= '0;
      segEnable <= 1'b0;
      segStart  <= 1'b0;
      segEnd    <= 1'b0;
      segEmpty  <= '0;
      segError  <= 1'b0;
    end else if (load) begin
      segData   <= take ? word[`WORD_DATA_W-1:0] : '0;
      segEnable <= take;
      segStart  <= take && isStart;
      segEnd    <= wordEnd;
      segEmpty  <= wordEnd ? word[`FW_EMPTY_LSB +: `FW_EMPTY_W] : '0;
      segError  <= wordEnd && word[`FW_ERROR];
    end
  end

  property p_empty_only_end;
    @(posedge core_clk) disable iff (!rst_n)
      !segEnd |-> (segEmpty == 3'h0);
  endproperty
  a_empty_only_end: assert property (p_empty_only_end) else $error("empty set off end");

endmodule

// ### logic/eth_tx_source.sv
// Packet source that feeds a 40/50G MAC transmit stream in segmented or 256-bit layout.
`timescale 1ns/1ps
`include "eth_tx_cfg.svh"

module eth_tx_source
  import eth_tx_pkg::*;
(
  input  wire logic                        core_clk,      // 100 MHz clock, also the bus clock.
  input  wire logic                        rst_n,         // Synchronous reset, active low.
  input  wire logic                        wideMode,      // 1 selects 256-bit layout at reset.
  input  wire logic                        inValid,       // User word offered.
  output logic                             inReady,       // Buffer can take the word.
  input  wire logic [`WORD_DATA_W-1:0]     inData,        // Eight bytes, byte 0 low.
  input  wire logic                        inLast,        // Word ends the packet.
  input  wire logic [`FW_EMPTY_W-1:0]      inEmpty,       // Unused trailing bytes of last word.
  input  wire logic                        inError,       // Packet is bad, on last word.
  input  wire logic                        clrUnderflow,  // Clears the underflow record.
  output logic                             underflowSeen, // Sticky record of device underflow.
  output logic                             txReset,       // Device transmit reset, active high.
  output logic                             auxClk,        // Divided auxiliary clock.
  input  wire logic                        txReady,       // Device ready.
  input  wire logic                        txUnderflow,   // Device underflow indicator.
  output logic                             segValid,      // Segmented bus valid.
  output logic [`SEG_BUS_W-1:0]            segData,       // Segment 1 high, segment 0 low.
  output logic                             seg0_transfer_enable, // Segment 0 enable.
  output logic                             seg1_transfer_enable, // Segment 1 enable.
  output logic                             seg0_frame_start,     // Frame starts in segment 0.
  output logic                             seg1_frame_start,     // Frame starts in segment 1.
  output logic                             seg0_frame_end,       // Frame ends in segment 0.
  output logic                             seg1_frame_end,       // Frame ends in segment 1.
  output logic [`FW_EMPTY_W-1:0]           seg0_empty_count,     // Segment 0 empty bytes.
  output logic [`FW_EMPTY_W-1:0]           seg1_empty_count,     // Segment 1 empty bytes.
  output logic                             seg0_packet_error,    // Segment 0 packet error.
  output logic                             seg1_packet_error,    // Segment 1 packet error.
  output logic                             wideValid,     // 256-bit bus valid.
  output logic [`WIDE_BUS_W-1:0]           wideData,      // 256-bit data.
  output logic [`WIDE_KEEP_W-1:0]          wideKeep,      // Byte lane qualifiers.
  output logic                             wideLast,      // Packet ends in this beat.
  output logic                             wideError      // Bad packet flag.
);

  // Register state.
  link_state_type                   state_ff;
  logic [`HOLD_CNT_W-1:0]           holdCnt_ff;
  logic                             modeWide_ff;
  logic                             outValid_ff;
  logic                             inFrame_ff;
  logic [`FIFO_LEVEL_W-1:0]         frameCnt_ff;
  logic                             underflow_ff;
  logic                             aux_ff;
  logic [`WIDE_BUS_W-1:0]           wideData_ff;
  logic [`WIDE_KEEP_W-1:0]          wideKeep_ff;
  logic                             wideLast_ff;
  logic                             wideError_ff;

  // Buffer read side.
  buf_word_type [`WIDE_WORDS-1:0]   heads;
  logic [`FIFO_LEVEL_W-1:0]         level;
  logic                             fifoValid;
  logic [2:0]                       popNum;
  logic                             anyTake;
  logic [`FIFO_LEVEL_W-1:0]         poppedLasts;
  logic [`WIDE_BUS_W-1:0]           nxt_wideData;
  logic [`WIDE_KEEP_W-1:0]          nxt_wideKeep;

  // Small word buffer between the user and the bus; it absorbs bursts and lets a
  // frame be fully staged before it starts, so a frame shorter than the buffer never starves mid-frame.
  stream_fifo #(
    .WIDTH (`WORD_W),
    .DEPTH (`FIFO_DEPTH),
    .LANES (`WIDE_WORDS)
  ) u_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wrValid  (inValid),
    .wrReady  (inReady),
    .wrData   ({inError, inEmpty, inLast, inData}),
    .rdValid  (fifoValid),
    .rdReady  (anyTake),
    .rdPop    (popNum),
    .rdHeads  (heads),
    .rdLevel  (level)
  );

  // Status decodes.
  wire running   = (state_ff == ST_RUN);
  wire fifoFull  = (level == `FIFO_LEVEL_W'(`FIFO_DEPTH));
  wire canLoad   = running && (!outValid_ff || txReady);
  wire pushLast  = inValid && inReady && inLast;

  // Word flags at the heads of the buffer.
  wire last0     = heads[0][`FW_LAST];
  wire last1     = heads[1][`FW_LAST];
  wire last2     = heads[2][`FW_LAST];
  wire sop0      = !inFrame_ff;
  wire sop1      = last0;

  // A frame may start only when its end is already buffered, or the buffer is full
  // and can hold no more; a frame longer than the buffer can therefore still starve.
  wire startOk0  = !sop0 || (frameCnt_ff >= `FIFO_LEVEL_W'(1)) || fifoFull;
  wire startOk1  = (frameCnt_ff >= `FIFO_LEVEL_W'(2)) || fifoFull;

  // Segmented layout: segment 0 takes the older word, segment 1 the next one.
  wire take0     = (level >= `FIFO_LEVEL_W'(1)) && startOk0;
  wire pairBad   = last0 && (last1 || sop0);
  wire take1     = take0 && (level >= `FIFO_LEVEL_W'(2))
                   && (!sop1 || startOk1) && !pairBad;
  wire [2:0] segPop = {2'b00, take0} + {2'b00, take1};

  // Wide layout: a beat ends at the first last word, never straddles packets.
  wire [2:0] wideCnt = last0 ? 3'd1 : (last1 ? 3'd2 : (last2 ? 3'd3 : 3'd4));
  wire wideTake  = (level >= `FIFO_LEVEL_W'(wideCnt)) && startOk0;

  // Words taken this cycle, and whether the last one taken closes a frame.
  assign popNum  = !canLoad ? 3'd0 : (modeWide_ff ? (wideTake ? wideCnt : 3'd0) : segPop);
  assign anyTake = (popNum != 3'd0);
  wire [1:0] lastIdx = 2'(popNum - 3'd1);
  wire takenEnd  = heads[lastIdx][`FW_LAST];

  // Count last words among those popped, for the buffered frame tally.
  always_comb begin
    poppedLasts = '0;
    for (int i = 0; i < `WIDE_WORDS; i++) begin
      if (3'(i) < popNum && heads[i][`FW_LAST]) begin
        poppedLasts = poppedLasts + `FIFO_LEVEL_W'(1);
      end
    end
  end

  // Pack the wide beat: word i fills lanes 8i..8i+7, earlier bytes in lower lanes;
  // keep is trimmed only on the last word, from its empty count.
  always_comb begin
    nxt_wideData = '0;
    nxt_wideKeep = '0;
    for (int i = 0; i < `WIDE_WORDS; i++) begin
      if (3'(i) < wideCnt) begin
        nxt_wideData[i*`WORD_DATA_W +: `WORD_DATA_W] = heads[i][`WORD_DATA_W-1:0];
        nxt_wideKeep[i*`SEG_BYTES +: `SEG_BYTES] = heads[i][`FW_LAST]
            ? (8'hFF >> heads[i][`FW_EMPTY_LSB +: `FW_EMPTY_W])
            : 8'hFF;
      end
    end
  end

  // Two segment lanes of the segmented layout.
  seg_lane u_seg0 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .load      (canLoad && !modeWide_ff),
    .take      (take0),
    .isStart   (sop0),
    .word      (heads[0]),
    .segData   (segData[`WORD_DATA_W-1:0]),
    .segEnable (seg0_transfer_enable),
    .segStart  (seg0_frame_start),
    .segEnd    (seg0_frame_end),
    .segEmpty  (seg0_empty_count),
    .segError  (seg0_packet_error)
  );

  seg_lane u_seg1 (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .load      (canLoad && !modeWide_ff),
    .take      (take1),
    .isStart   (sop1),
    .word      (heads[1]),
    .segData   (segData[`SEG_BUS_W-1:`WORD_DATA_W]),
    .segEnable (seg1_transfer_enable),
    .segStart  (seg1_frame_start),
    .segEnd    (seg1_frame_end),
    .segEmpty  (seg1_empty_count),
    .segError  (seg1_packet_error)
  );

  // Reset sequencer: the device reset stays high through our reset and a settle
  // time after it, so the device sees a clean clock before it comes out.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff    <= ST_HOLD;
      holdCnt_ff  <= '0;
      modeWide_ff <= wideMode;
    end else begin
      case (state_ff)
        ST_HOLD: begin
          holdCnt_ff <= holdCnt_ff + `HOLD_CNT_W'(1);
          if (holdCnt_ff == `HOLD_CNT_W'(`RESET_HOLD_CYC - 1)) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_HOLD;
        end
      endcase
    end
  end

  // Beat valid, frame tracking and the tally of whole frames held in the buffer.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      outValid_ff <= 1'b0;
      inFrame_ff  <= 1'b0;
      frameCnt_ff <= '0;
    end else begin
      outValid_ff <= canLoad ? anyTake : outValid_ff;
      inFrame_ff  <= anyTake ? !takenEnd : inFrame_ff;
      frameCnt_ff <= frameCnt_ff + `FIFO_LEVEL_W'(pushLast) - poppedLasts;
    end
  end

  // Wide beat registers change only when the previous beat was taken or none stood.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wideData_ff  <= '0;
      wideKeep_ff  <= '0;
      wideLast_ff  <= 1'b0;
      wideError_ff <= 1'b0;
    end else if (canLoad && modeWide_ff) begin
      wideData_ff  <= wideTake ? nxt_wideData : '0;
      wideKeep_ff  <= wideTake ? nxt_wideKeep : '0;
      wideLast_ff  <= wideTake && heads[lastIdx][`FW_LAST];
      wideError_ff <= wideTake && heads[lastIdx][`FW_LAST]
                      && heads[lastIdx][`FW_ERROR];
    end
  end

  // Underflow record; a new underflow in the clearing cycle wins over the clear.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      underflow_ff <= 1'b0;
    end else begin
      underflow_ff <= txUnderflow || (underflow_ff && !clrUnderflow);
    end
  end

  // Auxiliary clock for the device, divided by two; it runs freely from reset on.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aux_ff <= 1'b0;
    end else begin
      aux_ff <= !aux_ff;
    end
  end

  // Output drive, all from flip-flops except the valids, which split by layout, and txReset, decoded from the state.
  assign segValid      = outValid_ff && !modeWide_ff;
  assign wideValid     = outValid_ff && modeWide_ff;
  assign wideData      = wideData_ff;
  assign wideKeep      = wideKeep_ff;
  assign wideLast      = wideLast_ff;
  assign wideError     = wideError_ff;
  assign txReset       = (state_ff != ST_RUN);
  assign underflowSeen = underflow_ff;
  assign auxClk        = aux_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_one_start;
    segValid |-> !(seg0_frame_start && seg1_frame_start);
  endproperty
  a_one_start: assert property (p_one_start) else $error("two starts in a cycle");

  property p_one_end;
    segValid |-> !(seg0_frame_end && seg1_frame_end);
  endproperty
  a_one_end: assert property (p_one_end) else $error("two ends in a cycle");

  property p_error_on_end;
    (seg0_packet_error |-> seg0_frame_end && seg0_transfer_enable)
      and (seg1_packet_error |-> seg1_frame_end && seg1_transfer_enable);
  endproperty
  a_error_on_end: assert property (p_error_on_end) else $error("error off end word");

  property p_seg_hold;
    segValid && !txReady |=> segValid && $stable(segData) && $stable(seg0_frame_end);
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("segment beat dropped");

  property p_wide_hold;
    wideValid && !txReady |=> wideValid && $stable(wideData) && $stable(wideKeep)
      && $stable(wideLast) && $stable(wideError);
  endproperty
  a_wide_hold: assert property (p_wide_hold) else $error("wide beat changed unaccepted");

  property p_reset_hold;
    $rose(rst_n) |-> txReset [*8];
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("device reset released early");

  property p_quiet_in_reset;
    txReset |-> !segValid && !wideValid;
  endproperty
  a_quiet_in_reset: assert property (p_quiet_in_reset) else $error("valid during reset");

  property p_valid_has_data;
    (segValid |-> seg0_transfer_enable) and (wideValid |-> wideKeep[0]);
  endproperty
  a_valid_has_data: assert property (p_valid_has_data) else $error("valid without data");

  property p_seg_order;
    seg1_transfer_enable |-> seg0_transfer_enable && segValid;
  endproperty
  a_seg_order: assert property (p_seg_order) else $error("segment 1 used alone");

  property p_wide_keep_full;
    wideValid && !wideLast |-> (wideKeep == 32'hFFFF_FFFF);
  endproperty
  a_wide_keep_full: assert property (p_wide_keep_full) else $error("partial keep mid packet");

  property p_underflow_sticky;
    txUnderflow |=> underflowSeen;
  endproperty
  a_underflow_sticky: assert property (p_underflow_sticky) else $error("underflow not recorded");

endmodule

// ### sim/mac_tx_model.sv
// Behavioural transmit MAC that takes beats, throttles ready and flags underflow.
`timescale 1ns/1ps
module mac_tx_model (
  input  wire logic core_clk,   // Interface clock.
  input  wire logic txReset,    // Transmit reset, active high.
  input  wire logic slow,       // Throttle ready by a pattern.
  input  wire logic stall,      // Hold ready low.
  input  wire logic unfReq,     // Raise underflow.
  output logic      txReady,    // Beat taken.
  output logic      txUnderflow // Underflow flag.
);
  logic [3:0] pat;
  // A wandering pattern makes beats stand for uneven times, not just one.
  always_ff @(posedge core_clk) begin
    pat <= txReset ? 4'h1 : {pat[2:0], pat[3] ^ pat[2]};
  end
  // Nothing is taken while the reset is held.
  assign txReady = !txReset && !stall && (!slow || pat[0]);
  assign txUnderflow = unfReq && !txReset;
endmodule

// ### sim/eth_tx_source_tb_top.sv
// Self-checking bench for the transmit packet source in both layouts.
`timescale 1ns/1ps
module eth_tx_source_tb_top;
  logic core_clk, rst_n, wideMode, inValid, inLast, inError, clr, inReady;
  logic slow, stall, unfReq, txReady, txUnf, uSeen, txReset, segValid;
  logic wideValid, wideLast, wideError, aux, a0;
  logic [1:0] sEn, sSt, sEnd, sErr;
  logic [2:0] inEmpty, sMt0, sMt1;
  logic [63:0] inData;
  logic [127:0] segData;
  logic [255:0] wideData;
  logic [31:0] wideKeep, seed;
  logic [289:0] sq[$], wq[$], e, s;
  int err_total, cmp_count, cyc;

  eth_tx_source u_dut (.core_clk(core_clk), .rst_n(rst_n), .wideMode(wideMode),
    .inValid(inValid), .inReady(inReady), .inData(inData), .inLast(inLast),
    .inEmpty(inEmpty), .inError(inError), .clrUnderflow(clr), .underflowSeen(uSeen),
    .txReset(txReset), .auxClk(aux), .txReady(txReady), .txUnderflow(txUnf),
    .segValid(segValid), .segData(segData), .seg0_transfer_enable(sEn[0]),
    .seg1_transfer_enable(sEn[1]), .seg0_frame_start(sSt[0]), .seg1_frame_start(sSt[1]),
    .seg0_frame_end(sEnd[0]), .seg1_frame_end(sEnd[1]), .seg0_empty_count(sMt0),
    .seg1_empty_count(sMt1), .seg0_packet_error(sErr[0]), .seg1_packet_error(sErr[1]),
    .wideValid(wideValid), .wideData(wideData), .wideKeep(wideKeep),
    .wideLast(wideLast), .wideError(wideError));
  mac_tx_model u_mac (.core_clk(core_clk), .txReset(txReset), .slow(slow),
    .stall(stall), .unfReq(unfReq), .txReady(txReady), .txUnderflow(txUnf));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [289:0] sv(int i);
    return {220'h0, sSt[i], sEnd[i], i ? sMt1 : sMt0, sErr[i], segData[64*i +: 64]};
  endfunction
  task automatic ck(string n, logic [289:0] x, logic [289:0] y);
    cmp_count++;
    if (x !== y) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Pushes one packet word by word; the non-last words carry junk empty and error.
  // An idle edge follows, so valid never falls and rises again in one time step.
  task automatic send_pkt(int n, logic [2:0] mt, logic er);
    logic [63:0] d;
    logic l;
    logic [289:0] w;
    w = '0;
    for (int i = 0; i < n; i++) begin
      d = {rnd(), rnd()};
      l = (i == n - 1);
      {inValid, inData, inLast, inEmpty, inError} = {1'b1, d, l, mt, er};
      if (!wideMode) sq.push_back({220'h0, i == 0, l, l ? mt : 3'h0, l & er, d});
      w[64*i +: 64] = d;
      w[256 + 8*i +: 8] = l ? 8'hff >> mt : 8'hff;
      while (inReady !== 1'b1) @(posedge core_clk) #1;
      @(posedge core_clk) #1;
    end
    inValid = 0;
    if (wideMode) wq.push_back({er, 1'b1, w[287:0]});
    @(posedge core_clk) #1;
  endtask

  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // Each taken beat pops the oldest note; segment 0 is always older than segment 1.
  always @(posedge core_clk) begin
    cyc++;
    if (rst_n && segValid === 1'b1 && txReady === 1'b1) begin
      if (sEn[0] === 1'b1) ck("seg0", sq.pop_front(), sv(0));
      if (sEn[1] === 1'b1) ck("seg1", sq.pop_front(), sv(1));
    end
    if (rst_n && wideValid === 1'b1 && txReady === 1'b1) begin
      e = wq.pop_front();
      s = {wideError, wideLast, wideKeep, wideData};
      // Empty lanes carry no data, so they are blanked on both sides.
      for (int j = 0; j < 32; j++) begin
        if (!e[256 + j]) begin
          s[8*j +: 8] = 8'h0;
          e[8*j +: 8] = 8'h0;
        end
      end
      ck("wide", e, s);
    end
  end
  // Both layouts run the same sequence, each after its own reset.
  initial begin
    {rst_n, wideMode, inValid, inLast, inError, clr, slow, stall, unfReq} = '0;
    {inData, inEmpty} = '0;
    seed = 32'h833e_6cee;
    fork
      for (int m = 0; m < 2; m++) begin
        wideMode = m[0];
        rst_n = 0;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1;
        repeat (15) @(posedge core_clk);
        #1 ck("txReset", 1, txReset);
        repeat (2) @(posedge core_clk);
        #1 ck("txReset", 0, txReset);
        a0 = aux;
        @(posedge core_clk) #1;
        ck("auxClk", !a0, aux);
        repeat (12) send_pkt(rnd() % 4 + 1, 3'(rnd()), 1'(rnd()));
        slow = 1;
        repeat (10) send_pkt(rnd() % 4 + 1, 3'(rnd()), 1'(rnd()));
        // Drain first: only the single beat loaded after the stall is raised leaves the buffer,
        // two words in segmented layout and four in wide, so the fill ends exactly full.
        while (sq.size() + wq.size() > 0) @(posedge core_clk) #1;
        stall = 1;
        repeat (8) send_pkt(4, 3'(rnd()), 1'(rnd()));
        send_pkt(wideMode ? 4 : 2, 3'(rnd()), 1'(rnd()));
        ck("inReady", 0, inReady);
        {slow, stall, unfReq} = 3'b001;
        @(posedge core_clk) #1;
        unfReq = 0;
        ck("underflow", 1, uSeen);
        clr = 1;
        @(posedge core_clk) #1;
        clr = 0;
        ck("underflow", 0, uSeen);
        while (sq.size() + wq.size() > 0) @(posedge core_clk) #1;
      end
      begin
        // A hang anywhere above counts as a mismatch.
        wait (cyc == 40000);
        err_total++;
      end
    join_any
    print_verdict();
  end
endmodule
